// File: hw/acc_top.sv
// Calibration registers and result correction behind an APB slave
// ************************************************************
// ************************************************************
`timescale 1ns/1ps
module acc_top
    import acc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [acc_pkg::ADDR_W-1:0] paddr,
    input wire logic [acc_pkg::DATA_W-1:0] pwdata,
    input wire logic [acc_pkg::STRB_W-1:0] pstrb,
    output logic [acc_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic raw_valid,
    input wire logic [acc_pkg::RAW_W-1:0] raw_result,
    input wire logic raw_is_temp,
    input wire logic raw_is_tia,
    input wire logic [acc_pkg::PGA_W-1:0] programmable_gain_amp,
    output logic result_valid,
    output logic [acc_pkg::RAW_W-1:0] conversion_result
);

    // ********************************************************
    // Address decode
    // ********************************************************
    wire setup_phase;
    wire access_phase;
    wire wr_access;
    wire hit_temp_ofs;
    wire hit_gain9;
    wire hit_ofs9;
    wire hit_result;
    wire hit_ctrl;
    wire hit_stat;
    wire hit_any;

    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    assign wr_access = access_phase & pwrite & hit_any;
    assign hit_temp_ofs = (paddr == TEMP_OFS_ADDR);
    assign hit_gain9 = (paddr == GAIN9_ADDR);
    assign hit_ofs9 = (paddr == OFS9_ADDR);
    assign hit_result = (paddr == RESULT_ADDR);
    assign hit_ctrl = (paddr == CTRL_ADDR);
    assign hit_stat = (paddr == STAT_ADDR);
    assign hit_any = hit_temp_ofs | hit_gain9 | hit_ofs9
                   | hit_result | hit_ctrl | hit_stat;

    // ********************************************************
    // Byte lane merge
    // ********************************************************
    wire [DATA_W-1:0] lane_mask;

    genvar gi;
    generate
        for (gi = 0; gi < STRB_W; gi++) begin : g_lane
            assign lane_mask[gi*8 +: 8] = {8{pstrb[gi]}};
        end
    endgenerate

    function automatic logic [CAL_W-1:0] merge_cal(
        input logic [CAL_W-1:0] old,
        input logic [DATA_W-1:0] wdata,
        input logic [DATA_W-1:0] mask
    );
        logic [DATA_W-1:0] full;
        full = ({17'h0, old} & ~mask) | (wdata & mask);
        return full[CAL_W-1:0];
    endfunction : merge_cal

    // ********************************************************
    // Calibration registers
    // ********************************************************
    logic [CAL_W-1:0] temp_sensor_offset_cal_ff;
    logic [CAL_W-1:0] aux_gain_cal_pga_nine_ff;
    logic [CAL_W-1:0] aux_offset_cal_pga_nine_ff;
    logic corr_en_ff;
    wire [CAL_W-1:0] nxt_temp_ofs;
    wire [CAL_W-1:0] nxt_gain9;
    wire [CAL_W-1:0] nxt_ofs9;
    wire nxt_corr_en;

    assign nxt_temp_ofs = merge_cal(temp_sensor_offset_cal_ff,
                                    pwdata, lane_mask);
    assign nxt_gain9 = merge_cal(aux_gain_cal_pga_nine_ff,
                                 pwdata, lane_mask);
    assign nxt_ofs9 = merge_cal(aux_offset_cal_pga_nine_ff,
                                pwdata, lane_mask);
    assign nxt_corr_en = pstrb[0] ? pwdata[CTRL_EN_BIT] : corr_en_ff;

    // ********************************************************
    // Register write strobes
    // ********************************************************
    wire wr_temp_ofs;
    wire wr_gain9;
    wire wr_ofs9;
    wire wr_ctrl;

    assign wr_temp_ofs = wr_access & hit_temp_ofs;
    assign wr_gain9 = wr_access & hit_gain9;
    assign wr_ofs9 = wr_access & hit_ofs9;
    assign wr_ctrl = wr_access & hit_ctrl;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_sensor_offset_cal_ff <= OFS_RST;
        end else if (wr_temp_ofs) begin
            temp_sensor_offset_cal_ff <= nxt_temp_ofs;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_gain_cal_pga_nine_ff <= GAIN_RST;
        end else if (wr_gain9) begin
            aux_gain_cal_pga_nine_ff <= nxt_gain9;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_offset_cal_pga_nine_ff <= OFS_RST;
        end else if (wr_ofs9) begin
            aux_offset_cal_pga_nine_ff <= nxt_ofs9;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            corr_en_ff <= CTRL_EN_RST[0];
        end else if (wr_ctrl) begin
            corr_en_ff <= nxt_corr_en;
        end
    end

    // ********************************************************
    // Calibration pair selection
    // ********************************************************
    wire pga_is_nine;
    wire sel_temp;
    wire sel_aux9;
    wire [CAL_W-1:0] use_offset;
    wire [CAL_W-1:0] use_gain;

    assign pga_is_nine = (programmable_gain_amp == PGA_GAIN_NINE);
    assign sel_temp = corr_en_ff & raw_is_temp;
    assign sel_aux9 = corr_en_ff & ~raw_is_temp & ~raw_is_tia
                    & pga_is_nine;
    assign use_offset = sel_temp ? temp_sensor_offset_cal_ff :
                        sel_aux9 ? aux_offset_cal_pga_nine_ff :
                        OFS_RST;
    assign use_gain = sel_aux9 ? aux_gain_cal_pga_nine_ff :
                      GAIN_RST;

    // ********************************************************
    // Correction arithmetic
    // ********************************************************
    wire corr_valid;
    wire [RAW_W-1:0] corr_result;
    wire corr_zero_gain;

    acc_corr u_corr (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(raw_valid),
        .raw(raw_result),
        .offset(use_offset),
        .gain(use_gain),
        .out_valid(corr_valid),
        .result(corr_result),
        .zero_gain(corr_zero_gain)
    );

    // ********************************************************
    // Corrected result holding register
    // ********************************************************
    logic [RAW_W-1:0] result_ff;
    logic result_valid_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_ff <= RES_MIN;
        end else if (corr_valid) begin
            result_ff <= corr_result;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_valid_ff <= 1'b0;
        end else begin
            result_valid_ff <= corr_valid;
        end
    end

    assign result_valid = result_valid_ff;
    assign conversion_result = result_ff;

    // ********************************************************
    // Sticky status, write one to clear, set wins
    // ********************************************************
    logic new_result_ff;
    logic zero_gain_seen_ff;
    wire stat_clr_new;
    wire stat_clr_zero;
    wire nxt_new_result;
    wire nxt_zero_gain_seen;

    assign stat_clr_new = wr_access & hit_stat & pstrb[0]
                        & pwdata[STAT_NEW_BIT];
    assign stat_clr_zero = wr_access & hit_stat & pstrb[0]
                         & pwdata[STAT_ZGAIN_BIT];
    assign nxt_new_result = corr_valid
                          | (new_result_ff & ~stat_clr_new);
    assign nxt_zero_gain_seen = corr_zero_gain
                              | (zero_gain_seen_ff & ~stat_clr_zero);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            new_result_ff <= 1'b0;
        end else begin
            new_result_ff <= nxt_new_result;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_gain_seen_ff <= 1'b0;
        end else begin
            zero_gain_seen_ff <= nxt_zero_gain_seen;
        end
    end

    // ********************************************************
    // Read data mux
    // ********************************************************
    wire [DATA_W-1:0] rd_temp_ofs;
    wire [DATA_W-1:0] rd_gain9;
    wire [DATA_W-1:0] rd_ofs9;
    wire [DATA_W-1:0] rd_result;
    wire [DATA_W-1:0] rd_ctrl;
    wire [DATA_W-1:0] rd_stat;
    wire [DATA_W-1:0] nxt_prdata;

    assign rd_temp_ofs = {17'h0, temp_sensor_offset_cal_ff};
    assign rd_gain9 = {17'h0, aux_gain_cal_pga_nine_ff};
    assign rd_ofs9 = {17'h0, aux_offset_cal_pga_nine_ff};
    assign rd_result = {16'h0, result_ff};
    assign rd_ctrl = {31'h0, corr_en_ff};
    assign rd_stat = {30'h0, zero_gain_seen_ff, new_result_ff};
    assign nxt_prdata = hit_temp_ofs ? rd_temp_ofs :
                        hit_gain9 ? rd_gain9 :
                        hit_ofs9 ? rd_ofs9 :
                        hit_result ? rd_result :
                        hit_ctrl ? rd_ctrl :
                        hit_stat ? rd_stat :
                        32'h0;

    // ********************************************************
    // Read data and error capture in the setup cycle
    // ********************************************************
    logic [DATA_W-1:0] prdata_ff;
    logic pslverr_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0;
        end else if (setup_phase) begin
            prdata_ff <= pwrite ? 32'h0 : nxt_prdata;
        end
    end

    // ********************************************************
    // Unmapped address flag, captured in the setup cycle
    // ********************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_ff <= 1'b0;
        end else if (setup_phase) begin
            pslverr_ff <= ~hit_any;
        end
    end

    // ********************************************************
    // APB answer, no wait states
    // ********************************************************
    assign pready = 1'b1;
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff & access_phase;

endmodule : acc_top

// File: hw/acc_pkg.sv
// Constants for the conversion result calibration block
package acc_pkg;

    // ********************************************************
    // Bus widths
    // ********************************************************
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    // ********************************************************
    // Register byte addresses
    // ********************************************************
    localparam logic [15:0] TEMP_OFS_ADDR = 16'h223c;
    localparam logic [15:0] GAIN9_ADDR = 16'h2298;
    localparam logic [15:0] OFS9_ADDR = 16'h22d0;
    localparam logic [15:0] RESULT_ADDR = 16'h2400;
    localparam logic [15:0] CTRL_ADDR = 16'h2404;
    localparam logic [15:0] STAT_ADDR = 16'h2408;

    // ********************************************************
    // Field layouts
    // ********************************************************
    localparam int CAL_W = 15;
    localparam int RAW_W = 16;
    localparam int FRAC_W = 14;
    localparam int QTR_W = 2;
    localparam int SUM_W = 20;
    localparam int PGA_W = 3;
    localparam int CTRL_EN_BIT = 0;
    localparam int STAT_NEW_BIT = 0;
    localparam int STAT_ZGAIN_BIT = 1;

    // ********************************************************
    // Reset values and codes
    // ********************************************************
    localparam logic [14:0] GAIN_RST = 15'h4000;
    localparam logic [14:0] OFS_RST = 15'h0000;
    localparam logic [14:0] GAIN_ZERO = 15'h0000;
    localparam logic [0:0] CTRL_EN_RST = 1'h1;
    localparam logic [2:0] PGA_GAIN_NINE = 3'h4;
    localparam logic [15:0] RES_MAX = 16'hffff;
    localparam logic [15:0] RES_MIN = 16'h0000;

endpackage : acc_pkg

// File: hw/acc_corr.sv
// Offset and gain correction arithmetic for one raw result
`timescale 1ns/1ps
module acc_corr
    import acc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    input wire logic [acc_pkg::RAW_W-1:0] raw,
    input wire logic [acc_pkg::CAL_W-1:0] offset,
    input wire logic [acc_pkg::CAL_W-1:0] gain,
    output logic out_valid,
    output logic [acc_pkg::RAW_W-1:0] result,
    output logic zero_gain
);

    // ********************************************************
    // Offset in quarter steps
    // ********************************************************
    wire signed [SUM_W-1:0] raw_q;
    wire signed [SUM_W-1:0] ofs_ext;
    wire signed [SUM_W-1:0] sum;
    assign raw_q = $signed({2'h0, raw, 2'h0});
    assign ofs_ext = $signed({{(SUM_W-CAL_W){offset[CAL_W-1]}},
                              offset});
    assign sum = raw_q + ofs_ext;

    // ********************************************************
    // Gain with fourteen fraction bits
    // ********************************************************
    wire signed [SUM_W+CAL_W:0] prod;
    wire signed [SUM_W-1:0] scaled;
    wire gain_is_zero;
    wire [RAW_W-1:0] nxt_result;
    assign prod = sum * $signed({1'b0, gain});
    assign scaled = prod[SUM_W+CAL_W:FRAC_W+QTR_W];
    assign gain_is_zero = (gain == GAIN_ZERO);
    assign nxt_result = gain_is_zero ? RES_MIN :
                        scaled[SUM_W-1] ? RES_MIN :
                        (|scaled[SUM_W-2:RAW_W]) ? RES_MAX :
                        scaled[RAW_W-1:0];

    // ********************************************************
    // Output stage
    // ********************************************************
    logic out_valid_ff;
    logic [RAW_W-1:0] result_ff;
    logic zero_gain_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid_ff <= 1'b0;
            result_ff <= RES_MIN;
            zero_gain_ff <= 1'b0;
        end else begin
            out_valid_ff <= in_valid;
            zero_gain_ff <= in_valid & gain_is_zero;
            if (in_valid) begin
                result_ff <= nxt_result;
            end
        end
    end

    assign out_valid = out_valid_ff;
    assign result = result_ff;
    assign zero_gain = zero_gain_ff;

endmodule : acc_corr

// File: test/acc_chk.sv
// Port checker for the calibration block
`timescale 1ns/1ps
module acc_chk
    import acc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [acc_pkg::ADDR_W-1:0] paddr,
    input wire logic [acc_pkg::DATA_W-1:0] pwdata,
    input wire logic [acc_pkg::STRB_W-1:0] pstrb,
    input wire logic [acc_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic raw_valid,
    input wire logic [acc_pkg::RAW_W-1:0] raw_result,
    input wire logic raw_is_temp,
    input wire logic raw_is_tia,
    input wire logic [acc_pkg::PGA_W-1:0] programmable_gain_amp,
    input wire logic result_valid,
    input wire logic [acc_pkg::RAW_W-1:0] conversion_result
);
    import acc_pkg::*;
    logic [14:0] g9_ff, o9_ff, ot_ff, nxt_g9, nxt_o9, nxt_ot;
    logic en_ff, nxt_en, wr, aux9, rd_cal;
    function automatic logic [14:0] mrg(input logic [14:0] o,
        input logic [31:0] d, input logic [3:0] s);
        return {s[1] ? d[14:8] : o[14:8], s[0] ? d[7:0] : o[7:0]};
    endfunction : mrg
    // ********************************************************
    // Shadow registers
    // ********************************************************
    assign wr = psel && penable && pwrite;
    assign nxt_g9 = (wr && paddr == GAIN9_ADDR) ?
        mrg(g9_ff, pwdata, pstrb) : g9_ff;
    assign nxt_o9 = (wr && paddr == OFS9_ADDR) ?
        mrg(o9_ff, pwdata, pstrb) : o9_ff;
    assign nxt_ot = (wr && paddr == TEMP_OFS_ADDR) ?
        mrg(ot_ff, pwdata, pstrb) : ot_ff;
    assign nxt_en = (wr && paddr == CTRL_ADDR && pstrb[0]) ? pwdata[0] : en_ff;
    assign aux9 = raw_valid && en_ff && !raw_is_temp && !raw_is_tia
        && programmable_gain_amp == PGA_GAIN_NINE;
    assign rd_cal = psel && penable && !pwrite && (paddr == OFS9_ADDR
        || paddr == GAIN9_ADDR || paddr == TEMP_OFS_ADDR);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            g9_ff <= GAIN_RST;
            o9_ff <= OFS_RST;
            ot_ff <= OFS_RST;
            en_ff <= CTRL_EN_RST;
        end else begin
            g9_ff <= nxt_g9;
            o9_ff <= nxt_o9;
            ot_ff <= nxt_ot;
            en_ff <= nxt_en;
        end
    end
    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_pass;
        ##2 (conversion_result == $past(raw_result, 2));
    endsequence
    a_lat_two: assert property (
        raw_valid |-> ##2 result_valid) else $error("result late");
    a_valid_cause: assert property (
        result_valid |-> $past(raw_valid, 2)) else $error("stray result");
    a_result_hold: assert property (
        !result_valid |-> $stable(conversion_result)) else $error("drift");
    a_gain_zero: assert property (
        aux9 && g9_ff == GAIN_ZERO |-> ##2 conversion_result == 16'h0000)
        else $error("zero gain not zero");
    a_tia_bypass: assert property (
        raw_valid && !raw_is_temp && raw_is_tia |-> s_pass)
        else $error("tia corrected");
    a_pga_bypass: assert property (
        raw_valid && !raw_is_temp && programmable_gain_amp != PGA_GAIN_NINE
        |-> s_pass) else $error("other gain corrected");
    a_temp_zero: assert property (
        raw_valid && raw_is_temp && ot_ff == 15'h0000 |-> s_pass)
        else $error("temp zero offset changed");
    a_unity_pass: assert property (
        aux9 && g9_ff == GAIN_RST && o9_ff == OFS_RST |-> s_pass)
        else $error("unity changed");
    a_rsv_zero: assert property (
        rd_cal |-> prdata[31:15] == 17'h00000) else $error("reserved set");
    c_zero_gain: cover property (aux9 && g9_ff == GAIN_ZERO);
    c_temp: cover property (raw_valid && raw_is_temp);
    c_unmapped: cover property (psel && penable && pslverr);
endmodule : acc_chk

bind acc_top acc_chk i_chk (.*);

// File: test/test_acc_top.sv
// Self-checking bench for the calibration block
`timescale 1ns/1ps
module test_acc_top;
    import acc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, raw_valid = 1'b0, raw_is_temp = 1'b0;
    logic raw_is_tia = 1'b0, en = 1'b1, pready, pslverr, result_valid;
    logic [15:0] paddr = 16'h0000, raw_result = 16'h0000, conversion_result;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h3d, x, y;
    logic [3:0] pstrb = 4'h0;
    logic [2:0] programmable_gain_amp = 3'h0;
    logic [14:0] g9 = 15'h4000, o9 = 15'h0, ot = 15'h0;
    logic [32:0] rdq[$];
    logic [15:0] resq[$];
    logic [15:0] adr[4] = '{TEMP_OFS_ADDR, GAIN9_ADDR, OFS9_ADDR, CTRL_ADDR};
    logic [14:0] ofc[5] = '{15'h0, 15'h1, 15'h3fff, 15'h7fff, 15'h4000};
    logic [14:0] gnc[7] = '{15'h0, 15'h2000, 15'h4000, 15'h4001, 15'h7fff,
        15'h1, 15'h3fff};
    logic [15:0] last = 16'h0000;
    int err_total = 0, tests_run = 0;
    always #25 pclk = ~pclk;
    acc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .raw_valid(raw_valid), .raw_result(raw_result),
        .raw_is_temp(raw_is_temp), .raw_is_tia(raw_is_tia),
        .programmable_gain_amp(programmable_gain_amp),
        .result_valid(result_valid), .conversion_result(conversion_result));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [14:0] mrg(input logic [14:0] o,
        input logic [31:0] d, input logic [3:0] s);
        return {s[1] ? d[14:8] : o[14:8], s[0] ? d[7:0] : o[7:0]};
    endfunction : mrg
    function automatic logic [15:0] corr(input logic [15:0] r,
        input logic [14:0] o, input logic [14:0] g);
        logic signed [19:0] s;
        logic signed [40:0] p;
        s = $signed({2'b00, r, 2'b00}) + $signed({{5{o[14]}}, o});
        p = s * $signed({1'b0, g});
        p = p >>> 16;
        if (p < 0) return 16'h0000;
        if (p > 41'sh0ffff) return 16'hffff;
        return p[15:0];
    endfunction : corr
    // ********************************************************
    // Drivers
    // ********************************************************
    task automatic apb(input logic w, input logic [15:0] a,
        input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [15:0] a, input logic [31:0] d,
        input logic [3:0] s);
        apb(1'b1, a, d, s);
        if (a == GAIN9_ADDR) g9 = mrg(g9, d, s);
        if (a == OFS9_ADDR) o9 = mrg(o9, d, s);
        if (a == TEMP_OFS_ADDR) ot = mrg(ot, d, s);
        if (a == CTRL_ADDR && s[0]) en = d[0];
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [32:0] e);
        rdq.push_back(e);
        apb(1'b0, a, 32'h0, 4'h0);
    endtask : rd
    task automatic smp(input logic [15:0] r, input logic t, input logic i,
        input logic [2:0] g);
        logic [15:0] e;
        e = r;
        if (en && t) e = corr(r, ot, GAIN_RST);
        else if (en && !i && g == PGA_GAIN_NINE) e = corr(r, o9, g9);
        resq.push_back(e);
        last = e;
        @(posedge pclk);
        raw_valid <= 1'b1;
        raw_result <= r;
        raw_is_temp <= t;
        raw_is_tia <= i;
        programmable_gain_amp <= g;
    endtask : smp
    task automatic idle(input int n);
        @(posedge pclk);
        raw_valid <= 1'b0;
        $display("test %0d done", n);
    endtask : idle
    // ********************************************************
    // Monitor and verdict
    // ********************************************************
    task automatic chk_bus(input logic [32:0] e, input logic [32:0] s);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("BAD prdata exp %h got %h", e, s);
        end
    endtask : chk_bus
    task automatic chk_res(input logic [15:0] e, input logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("BAD conversion_result exp %h got %h", e, s);
        end
    endtask : chk_res
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1)
            chk_bus(rdq.pop_front(), {pslverr, prdata});
        if (result_valid === 1'b1)
            chk_res(resq.pop_front(), conversion_result);
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    initial begin
        #500us;
        err_total++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(TEMP_OFS_ADDR, {18'h0, OFS_RST});
        rd(GAIN9_ADDR, {18'h0, GAIN_RST});
        rd(OFS9_ADDR, {18'h0, OFS_RST});
        rd(16'h2200, 33'h100000000);
        for (int k = 0; k < 3; k++) begin
            wr(adr[k], 32'hffffffff, 4'hf);
            rd(adr[k], 33'h000007fff);
        end
        wr(GAIN9_ADDR, 32'h4000, 4'hf);
        wr(TEMP_OFS_ADDR, 32'h0, 4'hf);
        idle(1);
        foreach (ofc[k]) begin
            wr(OFS9_ADDR, {17'h0, ofc[k]}, 4'hf);
            x = rnd();
            smp(x[15:0], 1'b0, 1'b0, PGA_GAIN_NINE);
            smp(16'h0000, 1'b0, 1'b0, PGA_GAIN_NINE);
            smp(16'hffff, 1'b0, 1'b0, PGA_GAIN_NINE);
            smp(x[31:16], 1'b1, 1'b0, x[2:0]);
            idle(2);
        end
        wr(OFS9_ADDR, 32'h0, 4'hf);
        foreach (gnc[k]) begin
            wr(GAIN9_ADDR, {17'h0, gnc[k]}, 4'hf);
            x = rnd();
            smp(x[15:0], 1'b0, 1'b0, PGA_GAIN_NINE);
            smp(16'hffff, 1'b0, 1'b0, PGA_GAIN_NINE);
            idle(3);
        end
        repeat (40) begin
            x = rnd();
            wr(adr[x[1:0]], rnd(), x[7:4]);
            repeat (3) begin
                y = rnd();
                smp(y[15:0], y[16], y[17], y[20:18]);
            end
            idle(4);
        end
        rd(TEMP_OFS_ADDR, {18'h0, ot});
        rd(GAIN9_ADDR, {18'h0, g9});
        rd(OFS9_ADDR, {18'h0, o9});
        rd(RESULT_ADDR, {17'h0, last});
        rd(CTRL_ADDR, {32'h0, en});
        rd(STAT_ADDR, 33'h000000003);
        wr(STAT_ADDR, 32'h3, 4'h1);
        rd(STAT_ADDR, 33'h000000000);
        repeat (4) @(posedge pclk);
        if (rdq.size() + resq.size() != 0) err_total++;
        finish_test();
    end
endmodule : test_acc_top
